// *** dv/tkscan_chk.sv ***
// port-level checks of the scan controller
// assumes binding into tkscan_top
`timescale 1ns/1ps
module tkscan_chk (
    input wire logic       sys_clk,    // clock
    input wire logic       rst_b,      // reset, active low
    input wire logic       host_ack,   // ack
    input wire logic       latch_wr,   // latch write
    input wire logic [7:0] latch_data, // latch data
    input wire logic [7:0] cf_led,     // led drive
    input wire logic       touch_irq,  // touch irq
    input wire logic       key_irq,    // key irq
    input wire logic [5:0] touch_zone, // stored zone
    input wire logic [7:0] rd_keys,    // stored keys
    input wire logic [5:0] sel_addr,   // select
    input wire logic       emit_en,    // emitter
    input wire logic [7:0] col_sel     // column drive
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    property p_col_onehot; $onehot0(col_sel); endproperty
    a_col_onehot: assert property (p_col_onehot) else $error("column drive not one-hot");
    property p_latch; latch_wr |=> cf_led == $past(latch_data); endproperty
    a_latch: assert property (p_latch) else $error("latch not on leds");
    property p_irq_hold; touch_irq && !host_ack |=> touch_irq; endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("touch irq dropped early");
    property p_zone_frz; touch_irq && !host_ack |=> $stable(touch_zone); endproperty
    a_zone_frz: assert property (p_zone_frz) else $error("zone changed while frozen");
    property p_keys_frz; $past(key_irq) && key_irq && !host_ack |=> $stable(rd_keys); endproperty
    a_keys_frz: assert property (p_keys_frz) else $error("keys changed while frozen");
    property p_ack; host_ack |=> !touch_irq && !key_irq; endproperty
    a_ack: assert property (p_ack) else $error("ack did not clear irq");
    property p_scan; emit_en |-> ##[1:110] !$stable(sel_addr); endproperty
    a_scan: assert property (p_scan) else $error("scan stalled");
    property p_zone; $rose(touch_irq) |-> touch_zone == $past(sel_addr); endproperty
    a_zone: assert property (p_zone) else $error("wrong zone stored");
    c_touch: cover property ($rose(touch_irq));
    c_key: cover property ($rose(key_irq));
    c_col: cover property (col_sel == 8'h02);
endmodule // tkscan_chk
bind tkscan_top tkscan_chk i_tkscan_chk (.sys_clk(sys_clk), .rst_b(rst_b), .host_ack(host_ack),
    .latch_wr(latch_wr), .latch_data(latch_data), .cf_led(cf_led), .touch_irq(touch_irq),
    .key_irq(key_irq), .touch_zone(touch_zone), .rd_keys(rd_keys), .sel_addr(sel_addr),
    .emit_en(emit_en), .col_sel(col_sel));

// *** dv/tkscan_host_model.sv ***
// host and touch panel stand-in for the scan controller
// assumes the bench sets its knobs at the falling edge
`timescale 1ns/1ps
module tkscan_host_model (
    input  wire logic       sys_clk,     // system clock
    input  wire logic       touch_irq,   // touch interrupt
    input  wire logic       key_irq,     // key interrupt
    input  wire logic [5:0] sel_addr,    // selected pair
    input  wire logic       emit_en,     // emitter enable
    input  wire logic       broken_on,   // finger present
    input  wire logic [5:0] broken_zone, // zone under finger
    input  wire logic [9:0] ack_wait,    // read time before ack
    output logic            beam_ok_pin, // detector lit
    output logic            host_ack     // ack pulse
);
    logic [9:0] cnt; // cycles since irq seen
    assign beam_ok_pin = emit_en && !(broken_on && sel_addr == broken_zone);
    initial begin
        cnt = 10'h000;
        host_ack = 1'b0;
    end
    always @(negedge sys_clk) begin
        // one-cycle pulse once the read time has run out
        host_ack <= (touch_irq || key_irq) && (cnt == ack_wait);
        if (touch_irq || key_irq)
            cnt <= cnt + 10'h001;
        else
            cnt <= 10'h000;
    end
endmodule // tkscan_host_model

// *** dv/tkscan_top_tb.sv ***
// self-checking bench of the scan controller
// assumes the host model and checker files are compiled first
`timescale 1ns/1ps
`include "tkscan_map.svh"
module tkscan_top_tb;
    logic sys_clk = 1'b0, rst_b = 1'b0, beam_ok_pin, host_ack, rd_touch, touch_irq, key_irq, emit_en;
    logic disp_wr = 1'b0, latch_wr = 1'b0, broken_on = 1'b0;
    logic [7:0] key_pin_b = 8'hff, rd_keys, col_sel, bar_drive, cf_led, disp_data = 8'h00, latch_data = 8'h00;
    logic [5:0] rd_zone = 6'h00, touch_zone, sel_addr, broken_zone = 6'h05;
    logic [2:0] disp_col = 3'h0;
    logic [9:0] ack_wait = 10'h190;
    int err_count = 0, tests_run = 0;
    tkscan_top i_tkscan_top (.sys_clk(sys_clk), .rst_b(rst_b), .beam_ok_pin(beam_ok_pin),
        .key_pin_b(key_pin_b), .host_ack(host_ack), .rd_zone(rd_zone), .rd_touch(rd_touch),
        .rd_keys(rd_keys), .touch_zone(touch_zone), .touch_irq(touch_irq), .key_irq(key_irq),
        .sel_addr(sel_addr), .emit_en(emit_en), .disp_wr(disp_wr), .disp_col(disp_col),
        .disp_data(disp_data), .col_sel(col_sel), .bar_drive(bar_drive), .latch_wr(latch_wr),
        .latch_data(latch_data), .cf_led(cf_led));
    tkscan_host_model i_tkscan_host_model (.sys_clk(sys_clk), .touch_irq(touch_irq), .key_irq(key_irq),
        .sel_addr(sel_addr), .emit_en(emit_en), .broken_on(broken_on), .broken_zone(broken_zone),
        .ack_wait(ack_wait), .beam_ok_pin(beam_ok_pin), .host_ack(host_ack));
    initial forever #20 sys_clk = ~sys_clk;
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // idle state and host latch
    task automatic t_latch;
        chk("irqs", {6'h00, touch_irq, key_irq}, 8'h00);
        chk("cf_led", cf_led, `TKSCAN_LATCH_RST);
        latch_data = 8'h5a;
        latch_wr = 1'b1;
        @(negedge sys_clk);
        latch_wr = 1'b0;
        chk("cf_led", cf_led, 8'h5a);
    endtask
    // touch at zone 5, freeze, then a new touch at zone 2
    task automatic t_touch;
        broken_on = 1'b1;
        repeat (500) if (touch_irq !== 1'b1) @(negedge sys_clk);
        chk("touch_irq", {7'h00, touch_irq}, 8'h01);
        chk("touch_zone", {2'h0, touch_zone}, 8'h05);
        broken_zone = 6'h02;
        repeat (200) @(negedge sys_clk);
        chk("zone_frozen", {2'h0, touch_zone}, 8'h05);
        rd_zone = 6'h05;
        @(negedge sys_clk);
        chk("rd_touch5", {7'h00, rd_touch}, 8'h01);
        rd_zone = 6'h04;
        @(negedge sys_clk);
        chk("rd_touch4", {7'h00, rd_touch}, 8'h00);
        repeat (400) if (touch_irq === 1'b1) @(negedge sys_clk);
        chk("touch_clear", {7'h00, touch_irq}, 8'h00);
        ack_wait = 10'h014;
        // scan must wrap the whole matrix before zone 2 comes round again
        repeat (4000) if (touch_irq !== 1'b1) @(negedge sys_clk);
        chk("zone_new", {2'h0, touch_zone}, 8'h02);
        broken_on = 1'b0;
        repeat (100) if (touch_irq === 1'b1) @(negedge sys_clk);
    endtask
    // hard key 2 pressed
    task automatic t_key;
        key_pin_b = 8'hfb;
        repeat (300) if (key_irq !== 1'b1) @(negedge sys_clk);
        @(negedge sys_clk);
        chk("rd_keys", rd_keys, 8'h04);
        key_pin_b = 8'hff;
        repeat (100) if (key_irq === 1'b1) @(negedge sys_clk);
        chk("key_clear", {7'h00, key_irq}, 8'h00);
    endtask
    // column 1 image shown when column 1 is driven
    task automatic t_disp;
        disp_col = 3'h1;
        disp_data = 8'ha5;
        disp_wr = 1'b1;
        @(negedge sys_clk);
        disp_wr = 1'b0;
        repeat (26000) if (col_sel !== 8'h02) @(negedge sys_clk);
        chk("col_sel", col_sel, 8'h02);
        chk("bar_drive", bar_drive, 8'ha5);
    endtask
    // watchdog against a hang
    initial begin
        repeat (60000) @(posedge sys_clk);
        err_count++;
        tally_and_finish;
    end
    initial begin
        repeat (6) @(negedge sys_clk);
        rst_b = 1'b1;
        repeat (3) @(negedge sys_clk);
        t_latch;
        t_touch;
        t_key;
        t_disp;
        tally_and_finish;
    end
endmodule // tkscan_top_tb

// *** rtl/tkscan_light_bar.sv ***
// column refresh of the 8x8 light-bar display memory
// assumes host writes are one-cycle strobes on sys_clk
`timescale 1ns/1ps
`include "tkscan_map.svh"
module tkscan_light_bar (
    input  wire logic       sys_clk,   // system clock
    input  wire logic       rst_q_b,   // synchronised reset, active low
    input  wire logic       wr_stb,    // host write of one column
    input  wire logic [2:0] wr_col,    // column written
    input  wire logic [7:0] wr_data,   // column bit image
    output logic      [7:0] col_sel,   // one-hot column drive
    output logic      [7:0] bar_drive  // bar outputs for this column
);
    logic [7:0]  dmem [8];             // display memory, columns of 8 bits
    logic [7:0]  next_dmem [8];        // next display memory
    logic [2:0]  col;                  // column being refreshed
    logic [2:0]  next_col;             // next column
    logic [15:0] tick;                 // column dwell counter
    logic [15:0] next_tick;            // next dwell count
    logic [7:0]  next_col_sel;         // next column drive
    logic [7:0]  next_bar_drive;       // next bar outputs

    // next display memory, refresh position and outputs
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            next_dmem[i] = dmem[i];
        end
        if (wr_stb) begin
            next_dmem[wr_col] = wr_data;
        end
        next_tick = tick + 16'h0001;
        next_col  = col;
        // RQ7 - column by column
        if (tick == 16'(`TKSCAN_COL_CYC - 1)) begin
            next_tick = 16'h0000;
            next_col  = col + 3'h1;
        end
        next_col_sel = 8'h01 << col;
        // RQ8 - lit when one
        next_bar_drive = dmem[col];
    end

    // register display state
    always_ff @(posedge sys_clk or negedge rst_q_b) begin
        if (!rst_q_b) begin
            for (int i = 0; i < 8; i++) begin
                dmem[i] <= 8'h00;
            end
            col       <= 3'h0;
            tick      <= 16'h0000;
            col_sel   <= 8'h00;
            bar_drive <= 8'h00;
        end else begin
            dmem      <= next_dmem;
            col       <= next_col;
            tick      <= next_tick;
            col_sel   <= next_col_sel;
            bar_drive <= next_bar_drive;
        end
    end
endmodule // tkscan_light_bar

// *** rtl/tkscan_map.svh ***
// timing counts, widths and reset values for the front-panel scan controller
// assumes inclusion by bare name from the package and the design modules
`ifndef TKSCAN_MAP_SVH
`define TKSCAN_MAP_SVH
`define TKSCAN_CLK_HZ        25000000
`define TKSCAN_DWELL_NS      2000
`define TKSCAN_DWELL_CYC     ((`TKSCAN_DWELL_NS * 25 + 999) / 1000)
`define TKSCAN_COL_US        500
`define TKSCAN_COL_CYC       ((`TKSCAN_COL_US * 25))
`define TKSCAN_ZONES         64
`define TKSCAN_KEYS          8
`define TKSCAN_COLS          8
`define TKSCAN_LATCH_RST     8'h00
`define TKSCAN_SEL_RST       6'h00
`endif

// *** rtl/tkscan_pkg.sv ***
// types shared by the scan controller files
// assumes the map header is on the include path
`include "tkscan_map.svh"
package tkscan_pkg;
    typedef logic [5:0] tkscan_sel_t;  // emitter/detector select
    typedef enum logic [1:0] {
        TKSCAN_SETTLE = 2'b00,         // emitter on, waiting for detector
        TKSCAN_SAMPLE = 2'b01,         // sample detector and keys
        TKSCAN_STEP   = 2'b10          // move to next zone
    } tkscan_state_e;
endpackage

// *** rtl/tkscan_sync.sv ***
// two flip-flop synchroniser for a bus of pin inputs
// assumes the pins are asynchronous to sys_clk
`timescale 1ns/1ps
module tkscan_sync #(
    parameter int W = 1                // width of the bus
) (
    input  wire logic         sys_clk, // system clock
    input  wire logic         rst_q_b, // synchronised reset, active low
    input  wire logic [W-1:0] d,       // asynchronous input
    output logic      [W-1:0] q        // synchronised output
);
    logic [W-1:0] meta;                // first stage, read only by q
    logic [W-1:0] next_meta;           // next first stage
    logic [W-1:0] next_q;              // next second stage

    // next values of both stages
    always_comb begin
        next_meta = d;
        next_q    = meta;
    end

    // register both stages
    always_ff @(posedge sys_clk or negedge rst_q_b) begin
        if (!rst_q_b) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= next_meta;
            q    <= next_q;
        end
    end
endmodule // tkscan_sync

// *** rtl/tkscan_top.sv ***
// front-panel touch scan, hard key scan and light-bar driver
// assumes a host on a simple byte strobe port, same clock as sys_clk
// Overview of operation
// RQ1 - keyboard scan and separate light-bar display
// RQ2 - scan touch zones continuously until beam broken
// RQ3 - detection ends scan, raises matching interrupt
// RQ4 - interrupt active freezes sensor memory, scan continues
// RQ5 - one emitter on, opposite detector only
// RQ6 - six-bit select picks emitter and detector
// RQ7 - display memory 8x8 refreshed column-wise
// RQ8 - bar lit when memory bit is one
// RQ9 - host latch drives coarse/fine LEDs directly
// RQ10 - coarse/fine sensed as ordinary touch zones
// RQ11 - host reads sensor memory, then acknowledges
`timescale 1ns/1ps
`include "tkscan_map.svh"
module tkscan_top (
    input  wire logic       sys_clk,        // 25 MHz system clock
    input  wire logic       rst_b,          // asynchronous reset, active low
    input  wire logic       beam_ok_pin,    // selected detector sees light
    input  wire logic [7:0] key_pin_b,      // hard keys, low when pressed
    input  wire logic       host_ack,       // host acknowledge pulse
    input  wire logic [5:0] rd_zone,        // sensor memory read index
    output logic            rd_touch,       // broken flag of rd_zone
    output logic [7:0]      rd_keys,        // stored key image
    output logic [5:0]      touch_zone,     // zone of stored touch
    output logic            touch_irq,      // touch interrupt to host
    output logic            key_irq,        // key interrupt to host
    output logic [5:0]      sel_addr,       // emitter and detector select
    output logic            emit_en,        // emitter enable
    input  wire logic       disp_wr,        // host display memory write
    input  wire logic [2:0] disp_col,       // column to write
    input  wire logic [7:0] disp_data,      // column image
    output logic [7:0]      col_sel,        // light-bar column drive
    output logic [7:0]      bar_drive,      // light-bar row drive
    input  wire logic       latch_wr,       // host coarse/fine latch write
    input  wire logic [7:0] latch_data,     // latch data
    output logic [7:0]      cf_led          // coarse/fine LED drive
);
    logic [1:0] rst_sync;                   // reset release stages
    logic       rst_q_b;                    // synchronised reset

    // reset released through two flip-flops
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_q_b = rst_sync[1];

    logic       beam_ok;                    // synchronised detector
    logic [7:0] key_b;                      // synchronised keys

    tkscan_sync #(.W(1)) u_beam_sync (
        .sys_clk (sys_clk),
        .rst_q_b (rst_q_b),
        .d       (beam_ok_pin),
        .q       (beam_ok)
    );

    tkscan_sync #(.W(8)) u_key_sync (
        .sys_clk (sys_clk),
        .rst_q_b (rst_q_b),
        .d       (key_pin_b),
        .q       (key_b)
    );

    // RQ1 - separate display function
    tkscan_light_bar u_light_bar (
        .sys_clk   (sys_clk),
        .rst_q_b   (rst_q_b),
        .wr_stb    (disp_wr),
        .wr_col    (disp_col),
        .wr_data   (disp_data),
        .col_sel   (col_sel),
        .bar_drive (bar_drive)
    );

    tkscan_pkg::tkscan_state_e state;       // scan state
    tkscan_pkg::tkscan_state_e next_state;  // next scan state
    tkscan_pkg::tkscan_sel_t   zone;        // zone under scan
    tkscan_pkg::tkscan_sel_t   next_zone;   // next zone
    logic [7:0]  dwell;                     // settle counter
    logic [7:0]  next_dwell;                // next settle count
    logic [63:0] touch_mem;                 // sensor memory, touch flags
    logic [63:0] next_touch_mem;            // next touch flags
    logic [63:0] frame;                     // flags collected this pass
    logic [63:0] next_frame;                // next pass flags
    logic [7:0]  key_mem;                   // sensor memory, keys
    logic [7:0]  next_key_mem;              // next keys
    logic [5:0]  next_touch_zone;           // next stored zone
    logic        next_touch_irq;            // next touch interrupt
    logic        next_key_irq;              // next key interrupt
    logic [5:0]  next_sel_addr;             // next select
    logic        next_emit_en;              // next emitter enable
    logic        next_rd_touch;             // next read flag
    logic [7:0]  next_rd_keys;              // next read keys
    logic [7:0]  next_cf_led;               // next latch value
    logic        frozen;                    // any interrupt active

    assign frozen = touch_irq | key_irq;

    // scan sequencer and sensor memory update
    always_comb begin
        next_state      = state;
        next_zone       = zone;
        next_dwell      = dwell;
        next_touch_mem  = touch_mem;
        next_frame      = frame;
        next_key_mem    = key_mem;
        next_touch_zone = touch_zone;
        next_touch_irq  = touch_irq;
        next_key_irq    = key_irq;
        // RQ11 - ack releases interrupt
        if (host_ack) begin
            next_touch_irq = 1'b0;
            next_key_irq   = 1'b0;
        end
        case (state)
            tkscan_pkg::TKSCAN_SETTLE: begin
                // emitter settling before the detector is sampled
                next_dwell = dwell + 8'h01;
                if (dwell == 8'(`TKSCAN_DWELL_CYC - 1)) begin
                    next_dwell = 8'h00;
                    next_state = tkscan_pkg::TKSCAN_SAMPLE;
                end
            end
            tkscan_pkg::TKSCAN_SAMPLE: begin
                // RQ10 - coarse/fine are zones
                next_frame[zone] = ~beam_ok;
                // RQ4 - frozen while interrupt
                if (!frozen) begin
                    // RQ3 - end scan, interrupt
                    if (!beam_ok) begin
                        next_touch_mem       = frame;
                        next_touch_mem[zone] = 1'b1;
                        next_touch_zone      = zone;
                        next_touch_irq       = 1'b1;
                        next_frame           = 64'h0;
                        next_zone            = `TKSCAN_SEL_RST;
                        next_state           = tkscan_pkg::TKSCAN_SETTLE;
                    end else if (key_b != 8'hff) begin
                        next_key_mem = ~key_b;
                        next_key_irq = 1'b1;
                        next_state   = tkscan_pkg::TKSCAN_STEP;
                    end else begin
                        next_state = tkscan_pkg::TKSCAN_STEP;
                    end
                end else begin
                    next_state = tkscan_pkg::TKSCAN_STEP;
                end
            end
            tkscan_pkg::TKSCAN_STEP: begin
                // RQ2 - continuous, no pause
                next_zone  = zone + 6'h01;
                next_state = tkscan_pkg::TKSCAN_SETTLE;
                if (zone == 6'h3f) begin
                    next_frame = 64'h0;
                end
            end
            default: begin
                next_state = tkscan_pkg::TKSCAN_SETTLE;
            end
        endcase
        // RQ5 - single emitter enabled
        next_emit_en  = 1'b1;
        // RQ6 - six-bit select
        next_sel_addr = next_zone;
        next_rd_touch = touch_mem[rd_zone];
        next_rd_keys  = key_mem;
        // RQ9 - host latch to LEDs
        next_cf_led   = latch_wr ? latch_data : cf_led;
    end

    // register scan state and outputs
    always_ff @(posedge sys_clk or negedge rst_q_b) begin
        if (!rst_q_b) begin
            state      <= tkscan_pkg::TKSCAN_SETTLE;
            zone       <= `TKSCAN_SEL_RST;
            dwell      <= 8'h00;
            touch_mem  <= 64'h0;
            frame      <= 64'h0;
            key_mem    <= 8'h00;
            touch_zone <= 6'h00;
            touch_irq  <= 1'b0;
            key_irq    <= 1'b0;
            sel_addr   <= `TKSCAN_SEL_RST;
            emit_en    <= 1'b0;
            rd_touch   <= 1'b0;
            rd_keys    <= 8'h00;
            cf_led     <= `TKSCAN_LATCH_RST;
        end else begin
            state      <= next_state;
            zone       <= next_zone;
            dwell      <= next_dwell;
            touch_mem  <= next_touch_mem;
            frame      <= next_frame;
            key_mem    <= next_key_mem;
            touch_zone <= next_touch_zone;
            touch_irq  <= next_touch_irq;
            key_irq    <= next_key_irq;
            sel_addr   <= next_sel_addr;
            emit_en    <= next_emit_en;
            rd_touch   <= next_rd_touch;
            rd_keys    <= next_rd_keys;
            cf_led     <= next_cf_led;
        end
    end
endmodule // tkscan_top
